// ---- aux_timer_defines.vh ----
`ifndef AUX_TIMER_DEFINES_VH
`define AUX_TIMER_DEFINES_VH

// register byte offsets
`define OFS_AUX_CONTROL       12'h000
`define OFS_AUX_COUNT         12'h004
`define OFS_CAPTURE_RELOAD    12'h008
`define OFS_CORE_CONTROL      12'h00c
`define OFS_IRQ_STATUS        12'h010
`define OFS_IRQ_MASK          12'h014

// auxiliary control field positions
`define INSEL_MSB             2
`define INSEL_LSB             0
`define MODE_MSB              5
`define MODE_LSB              3
`define RUN_BIT               6
`define DIR_BIT               7
`define REMOTE_BIT            9
`define SRC_BIT               10
`define CORR_BIT              11
`define EDGE_MSB              13
`define EDGE_LSB              12
`define CLR_BIT               14
`define CAPEN_BIT             15

// core control field positions (mirror layout)
`define TOGGLE_BIT            10
`define BPS_MSB               12
`define BPS_LSB               11
`define CORE_CONTROL_MASK     16'h1cff

// encodings
`define MODE_TIMER            3'h0
`define MODE_COUNTER          3'h1
`define INSEL_DISABLED        3'h0
`define EDGE_OFF              2'h0

// interrupt status bits
`define IRQ_AUX_BIT           0
`define IRQ_CAPTURE_BIT       1
`define IRQ_WIDTH             2

// reset values
`define RESET_CONTROL         16'h0000
`define RESET_COUNT           16'h0000
`define RESET_CAPTURE         16'h0000
`define RESET_IRQ             2'h0

// prescaler: largest division is 2 to this power
`define PRESCALE_MAX_SHIFT    11

`endif

// ---- pin_edge_sync.v ----
`timescale 1ns/100ps
// two-flop synchroniser per pin, then edge detection on the settled value
module pin_edge_sync #(
  parameter N = 3
) (
  // clock and reset
  input  wire         pclk,
  input  wire         presetn,
  // asynchronous pins
  input  wire [N-1:0] pin_in,
  // one-cycle edge pulses
  output wire [N-1:0] rise,
  output wire [N-1:0] fall
);

  reg [N-1:0] meta_r;
  reg [N-1:0] sync_r;
  reg [N-1:0] prev_r;
  reg [1:0]   warm_r;

  // edges are held off until prev_r holds a real pin sample, so a pin that
  // idles high gives no false edge after reset; edges in those cycles are lost
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      warm_r <= 2'h0;
    end else if (warm_r != 2'h3) begin
      warm_r <= warm_r + 2'h1;
    end
  end

  // only sync_r reads meta_r, to keep metastability out of the logic
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= {N{1'b0}};
      sync_r <= {N{1'b0}};
      prev_r <= {N{1'b0}};
    end else begin
      meta_r <= pin_in;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  genvar i;
  generate
    for (i = 0; i < N; i = i + 1) begin : g_edge
      assign rise[i] = (warm_r == 2'h3) & sync_r[i] & ~prev_r[i];
      assign fall[i] = (warm_r == 2'h3) & ~sync_r[i] & prev_r[i];
    end
  endgenerate

endmodule

// ---- block_prescaler.v ----
`timescale 1ns/100ps
`include "aux_timer_defines.vh"
// divides the hardware clock by base(block_prescaler_select) << input code
module block_prescaler #(
  parameter W = `PRESCALE_MAX_SHIFT
) (
  // clock and reset
  input  wire       pclk,
  input  wire       presetn,
  // configuration
  input  wire       run,
  input  wire [1:0] block_prescaler_select,
  input  wire [2:0] aux_input_select,
  // one-cycle tick per prescaled period
  output wire       tick
);

  reg  [W-1:0] div_cnt_r;
  reg  [3:0]   shift;
  wire [W-1:0] mask;

  // base 4, 2, 16, 8 as a power of two, doubled per input code step
  always @* begin
    case (block_prescaler_select)
      2'h0:    shift = 4'h2 + {1'b0, aux_input_select};
      2'h1:    shift = 4'h1 + {1'b0, aux_input_select};
      2'h2:    shift = 4'h4 + {1'b0, aux_input_select};
      default: shift = 4'h3 + {1'b0, aux_input_select};
    endcase
  end

  assign mask = ~({W{1'b1}} << shift);
  assign tick = run & ((div_cnt_r & mask) == mask);

  // held at zero while stopped so that the first period after run is a full one
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_r <= {W{1'b0}};
    end else if (!run) begin
      div_cnt_r <= {W{1'b0}};
    end else begin
      div_cnt_r <= div_cnt_r + {{(W-1){1'b0}}, 1'b1};
    end
  end

endmodule

// ---- aux_timer_capture_reload.v ----
`timescale 1ns/100ps
`include "aux_timer_defines.vh"
module aux_timer_capture_reload (
  // clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output wire        pslverr,
  output wire [31:0] prdata,
  // pins
  input  wire        capture_input_pin,
  input  wire        first_block_count_input,
  input  wire        first_block_direction_input,
  // core timer side, same clock
  input  wire        core_overflow,
  output wire        core_toggle_latch,
  output wire        core_run_enable,
  // interrupt
  output wire        irq
);

  // selects rise, fall or both from a two-bit code
  function edge_pick;
    input [1:0] code;
    input       r;
    input       f;
    begin
      case (code)
        2'h1:    edge_pick = r;
        2'h2:    edge_pick = f;
        2'h3:    edge_pick = r | f;
        default: edge_pick = 1'b0;
      endcase
    end
  endfunction

  // one offset compare shared by every write strobe
  function offset_hit;
    input [11:0] addr;
    input [11:0] offset;
    begin
      offset_hit = (addr == offset);
    end
  endfunction

  reg  [15:0] ctrl_r;
  reg  [15:0] core_ctrl_r;
  reg         toggle_r;
  reg         toggle_prev_r;
  reg  [15:0] count_r;
  reg  [15:0] count_nxt;
  reg  [15:0] capture_r;
  reg  [`IRQ_WIDTH-1:0] irq_status_r;
  reg  [`IRQ_WIDTH-1:0] irq_mask_r;
  reg  [31:0] prdata_r;
  reg  [31:0] rd_mux;
  reg         rd_hit;

  wire [2:0]  pin_rise;
  wire [2:0]  pin_fall;
  wire        pre_tick;
  wire        toggle_rise;
  wire        toggle_fall;
  wire        run;
  wire        count_tick;
  wire        pin_trig;
  wire        line_trig;
  wire        trig;
  wire        capture_event;
  wire        wrap_event;
  wire        wr;
  wire        rd_setup;
  wire        wr_ctrl;
  wire        wr_count;
  wire        wr_capture;
  wire        wr_core;
  wire        wr_status;
  wire        wr_mask;

  // field views
  wire [2:0] aux_input_select     = ctrl_r[`INSEL_MSB:`INSEL_LSB];
  wire [2:0] aux_mode_select      = ctrl_r[`MODE_MSB:`MODE_LSB];
  wire       aux_run_bit          = ctrl_r[`RUN_BIT];
  wire       aux_count_direction  = ctrl_r[`DIR_BIT];
  wire       aux_remote_run_select = ctrl_r[`REMOTE_BIT];
  wire       capture_source_select = ctrl_r[`SRC_BIT];
  wire       capture_correction   = ctrl_r[`CORR_BIT];
  wire [1:0] capture_edge_select  = ctrl_r[`EDGE_MSB:`EDGE_LSB];
  wire       clear_on_capture     = ctrl_r[`CLR_BIT];
  wire       capture_enable       = ctrl_r[`CAPEN_BIT];
  // core input, mode and run fields share the auxiliary layout; prescaler select has its own bits
  wire [2:0] core_input_select    = core_ctrl_r[`INSEL_MSB:`INSEL_LSB];
  wire [2:0] core_mode_select     = core_ctrl_r[`MODE_MSB:`MODE_LSB];
  wire       core_run_bit         = core_ctrl_r[`RUN_BIT];
  wire [1:0] block_prescaler_select = core_ctrl_r[`BPS_MSB:`BPS_LSB];

  // pins pass two flops before any edge logic
  pin_edge_sync #(
    .N (3)
  ) u_pins (
    .pclk    (pclk),
    .presetn (presetn),
    .pin_in  ({first_block_direction_input, first_block_count_input, capture_input_pin}),
    .rise    (pin_rise),
    .fall    (pin_fall)
  );

  // run source: own bit or the core timer's
  assign run = aux_remote_run_select ? core_run_bit : aux_run_bit;

  block_prescaler #(
    .W (`PRESCALE_MAX_SHIFT)
  ) u_prescale (
    .pclk                   (pclk),
    .presetn                (presetn),
    .run                    (run && aux_mode_select == `MODE_TIMER),
    .block_prescaler_select (block_prescaler_select),
    .aux_input_select       (aux_input_select),
    .tick                   (pre_tick)
  );

  // toggle latch edges for counter mode
  assign toggle_rise = toggle_r & ~toggle_prev_r;
  assign toggle_fall = ~toggle_r & toggle_prev_r;

  // counter mode only counts with the top code bit set; lower codes are inert
  assign count_tick = run & (
    (aux_mode_select == `MODE_TIMER) ? pre_tick :
    (aux_mode_select == `MODE_COUNTER) ?
      (aux_input_select[2] &
       edge_pick(aux_input_select[1:0], toggle_rise, toggle_fall)) :
    1'b0);

  // capture trigger sources
  assign pin_trig  = edge_pick(capture_edge_select, pin_rise[0], pin_fall[0]);
  assign line_trig = (capture_edge_select[0] & (pin_rise[1] | pin_fall[1])) |
                     (capture_edge_select[1] & (pin_rise[2] | pin_fall[2]));
  assign trig          = capture_source_select ? line_trig : pin_trig;
  assign capture_event = capture_enable & trig;

  // overflow when counting up past ffff, underflow when counting down past 0
  // a wrap in the cycle of a clear-on-capture is still reported
  assign wrap_event = count_tick &
                      (aux_count_direction ? (count_r == 16'h0000)
                                           : (count_r == 16'hffff));

  // apb decode; zero-wait slave, errors on unmapped offsets
  assign wr       = psel & penable & pwrite & (paddr[1:0] == 2'h0);
  assign rd_setup = psel & ~penable & ~pwrite;
  assign pready   = 1'b1;
  assign pslverr  = psel & penable & ~rd_hit;
  assign prdata   = prdata_r;

  // per-register write strobes; unaligned or unmapped writes match none
  assign wr_ctrl    = wr & offset_hit(paddr, `OFS_AUX_CONTROL);
  assign wr_count   = wr & offset_hit(paddr, `OFS_AUX_COUNT);
  assign wr_capture = wr & offset_hit(paddr, `OFS_CAPTURE_RELOAD);
  assign wr_core    = wr & offset_hit(paddr, `OFS_CORE_CONTROL);
  assign wr_status  = wr & offset_hit(paddr, `OFS_IRQ_STATUS);
  assign wr_mask    = wr & offset_hit(paddr, `OFS_IRQ_MASK);

  // read mux and address hit
  always @* begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    case (paddr)
      `OFS_AUX_CONTROL:    rd_mux = {16'h0000, ctrl_r};
      `OFS_AUX_COUNT:      rd_mux = {16'h0000, count_r};
      `OFS_CAPTURE_RELOAD: rd_mux = {16'h0000, capture_r};
      // live latch in place of its stale stored copy
      `OFS_CORE_CONTROL:   rd_mux = {16'h0000, core_ctrl_r[15:11], toggle_r,
                                     core_ctrl_r[9:0]};
      `OFS_IRQ_STATUS:     rd_mux = {30'h0000_0000, irq_status_r};
      `OFS_IRQ_MASK:       rd_mux = {30'h0000_0000, irq_mask_r};
      default:             rd_hit = 1'b0;
    endcase
  end

  // read data captured in setup so it comes from a flop in the access phase
  // a read therefore shows register contents as of its setup cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata_r <= rd_mux;
    end
  end

  // configuration registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r      <= `RESET_CONTROL;
      core_ctrl_r <= `RESET_CONTROL;
      irq_mask_r  <= `RESET_IRQ;
    end else if (wr) begin
      if (wr_ctrl) begin
        ctrl_r <= pwdata[15:0];
      end
      // only the kept core fields are stored; other bits read zero
      if (wr_core) begin
        core_ctrl_r <= pwdata[15:0] & `CORE_CONTROL_MASK;
      end
      if (wr_mask) begin
        irq_mask_r <= pwdata[`IRQ_WIDTH-1:0];
      end
    end
  end

  // toggle latch: hardware flip beats a software write in the same cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      toggle_r      <= 1'b0;
      toggle_prev_r <= 1'b0;
    end else begin
      toggle_prev_r <= toggle_r;
      if (core_overflow) begin
        toggle_r <= ~toggle_r;
      end else if (wr_core) begin
        toggle_r <= pwdata[`TOGGLE_BIT];
      end
    end
  end

  // core timer stays disabled in counter mode with input code 000
  assign core_run_enable = core_run_bit &
    ~(core_mode_select == `MODE_COUNTER && core_input_select == `INSEL_DISABLED);
  assign core_toggle_latch = toggle_r;

  // next count: capture clear beats counting, which beats a software write
  always @* begin
    count_nxt = count_r;
    if (wr_count) begin
      count_nxt = pwdata[15:0];
    end
    if (count_tick) begin
      count_nxt = aux_count_direction ? count_r - 16'h0001
                                      : count_r + 16'h0001;
    end
    // a tick lost to the clear is intended: the count restarts at the capture
    if (capture_event && clear_on_capture) begin
      count_nxt = 16'h0000;
    end
  end

  // counter and capture register; capture sees the value before clearing
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_r   <= `RESET_COUNT;
      capture_r <= `RESET_CAPTURE;
    end else begin
      count_r <= count_nxt;
      if (capture_event) begin
        // correcting a zero count wraps to ffff
        capture_r <= capture_correction ? count_r - 16'h0001 : count_r;
      end else if (wr_capture) begin
        capture_r <= pwdata[15:0];
      end
    end
  end

  // sticky status, write one to clear; a new event wins over the clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_r <= `RESET_IRQ;
    end else begin
      if (wr_status) begin
        irq_status_r <= irq_status_r & ~pwdata[`IRQ_WIDTH-1:0];
      end
      if (wrap_event) begin
        irq_status_r[`IRQ_AUX_BIT] <= 1'b1;
      end
      if (capture_event) begin
        irq_status_r[`IRQ_CAPTURE_BIT] <= 1'b1;
      end
    end
  end

  // level request: stays high until the status bit is cleared or masked
  assign irq = |(irq_status_r & irq_mask_r);

endmodule

// ---- aux_timer_monitor.sv ----
`timescale 1ns/100ps
module aux_timer_monitor (
  // clock and reset
  input wire        pclk,
  input wire        presetn,
  // apb
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire        pready,
  input wire        pslverr,
  input wire [31:0] prdata,
  // pins and core side
  input wire        capture_input_pin,
  input wire        first_block_count_input,
  input wire        first_block_direction_input,
  input wire        core_overflow,
  input wire        core_toggle_latch,
  input wire        core_run_enable,
  input wire        irq
);
  // access phase, unmapped offset, committed write to core control
  wire acc = psel && penable;
  wire bad = (paddr > 12'h014) || (paddr[1:0] != 2'h0);
  wire cwr = acc && pwrite && (paddr == 12'h00c);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_high: assert property (pready) else $error("ready low");
  a_err_unmapped: assert property (acc && bad |-> pslverr) else $error("no slave error");
  a_err_only: assert property (pslverr |-> acc && bad) else $error("stray slave error");
  a_read_zero: assert property (acc && !pwrite && bad |-> prdata == 32'h0) else $error("rd");
  a_upper_zero: assert property (acc |-> prdata[31:16] == 16'h0) else $error("upper bits");
  // read data must not move under the master as it samples
  a_read_hold: assert property (acc && !pwrite |=> $stable(prdata)) else $error("rd moved");
  a_toggle_flip: assert property (
    core_overflow |=> core_toggle_latch != $past(core_toggle_latch))
    else $error("latch did not flip");
  a_toggle_write: assert property (
    cwr && !core_overflow |=> core_toggle_latch == $past(pwdata[10]))
    else $error("latch write lost");
  a_toggle_hold: assert property (!core_overflow && !cwr |=> $stable(core_toggle_latch))
    else $error("latch moved");
  a_irq_masked: assert property (
    acc && pwrite && paddr == 12'h014 && pwdata[1:0] == 2'h0 |=> !irq)
    else $error("masked irq high");
  cover property (acc && bad);
  cover property (core_overflow);
  cover property ($rose(irq));
endmodule

bind aux_timer_capture_reload aux_timer_monitor i_mon (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pready(pready), .pslverr(pslverr), .prdata(prdata), .capture_input_pin(capture_input_pin),
  .first_block_count_input(first_block_count_input),
  .first_block_direction_input(first_block_direction_input), .core_overflow(core_overflow),
  .core_toggle_latch(core_toggle_latch), .core_run_enable(core_run_enable), .irq(irq));

// ---- tb_top.sv ----
`timescale 1ns/100ps
module tb_top;
  reg         pclk;
  reg         presetn;
  reg         psel;
  reg         penable;
  reg         pwrite;
  reg  [11:0] paddr;
  reg  [31:0] pwdata;
  reg         cap_pin;
  reg         cnt_in;
  reg         dir_in;
  reg         core_ovf;
  wire        pready;
  wire        pslverr;
  wire [31:0] prdata;
  wire        latch;
  wire        core_run;
  wire        irq;
  reg  [31:0] rd;
  reg         err;
  reg  [1:0]  e;
  reg         hit;
  integer     bad_count, tests_run, seed, cycles, i, k, v, c, d, exp, lat, capv;
  integer     cap_q[$];

  aux_timer_capture_reload i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .capture_input_pin(cap_pin),
    .first_block_count_input(cnt_in), .first_block_direction_input(dir_in),
    .core_overflow(core_ovf), .core_toggle_latch(latch), .core_run_enable(core_run),
    .irq(irq));

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  task check(input [31:0] seen, input [31:0] want);
    begin
      tests_run = tests_run + 1;
      if (seen !== want) begin
        bad_count = bad_count + 1;
        $display("Error at %0t seen %h want %h", $time, seen, want);
      end
    end
  endtask

  task close_out;
    begin
      $display("comparisons %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask

  // one apb transfer; an idle edge at the end keeps back-to-back calls clean
  task apb(input w, input [11:0] a, input [31:0] dat);
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= dat;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask

  // hang guard, far above the expected run of under a thousand cycles
  always @(posedge pclk) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      bad_count = bad_count + 1;
      close_out;
    end
  end

  initial begin
    seed = 21;
    bad_count = 0;
    tests_run = 0;
    cycles = 0;
    capv = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    cap_pin = 1'b0;
    cnt_in = 1'b0;
    dir_in = 1'b0;
    core_ovf = 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    // reset values, then one unmapped offset
    for (i = 0; i < 7; i = i + 1) begin
      apb(1'b0, {i[9:0], 2'h0}, 32'h0);
      check(rd, 32'h0);
      check(err, i == 6);
    end
    v = $random(seed);
    apb(1'b1, 12'h000, v);
    apb(1'b0, 12'h000, 32'h0);
    check(rd, v & 32'hffff);
    // stop whatever the random word started before the timed tests
    apb(1'b1, 12'h000, 32'h0);
    // timer mode, input code 1; odd passes run from the core run bit
    for (i = 0; i < 4; i = i + 1) begin
      d = (i == 0) ? 8 : (i == 1) ? 4 : (i == 2) ? 32 : 16;
      apb(1'b1, 12'h004, 32'h0);
      apb(1'b1, 12'h00c, {i[1:0], 11'h000} | ((i % 2) ? 32'h40 : 32'h0));
      apb(1'b1, 12'h000, (i % 2) ? 32'h201 : 32'h41);
      repeat (3 * d + d / 2 - 3) @(posedge pclk);
      apb(1'b1, 12'h000, 32'h0);
      apb(1'b0, 12'h004, 32'h0);
      check(rd, 3);
    end
    // down count through zero sets the overflow status
    apb(1'b1, 12'h004, 32'h0);
    apb(1'b1, 12'h010, 32'h3);
    apb(1'b1, 12'h00c, 32'h0);
    apb(1'b1, 12'h000, 32'hc1);
    repeat (25) @(posedge pclk);
    apb(1'b1, 12'h000, 32'h0);
    apb(1'b0, 12'h004, 32'h0);
    check(rd, 32'hfffd);
    apb(1'b1, 12'h014, 32'h1);
    check(irq, 1'b1);
    apb(1'b1, 12'h014, 32'h0);
    check(irq, 1'b0);
    apb(1'b1, 12'h014, 32'h1);
    apb(1'b1, 12'h010, 32'h1);
    check(irq, 1'b0);
    // random capture set-ups against random pin and line edges
    apb(1'b1, 12'h014, 32'h2);
    for (i = 0; i < 16; i = i + 1) begin
      v = $random(seed) & 32'hffff;
      c = $random(seed) & 32'hfc00;
      k = {$random(seed)} % 3;
      apb(1'b1, 12'h000, c);
      apb(1'b1, 12'h004, v);
      apb(1'b1, 12'h010, 32'h3);
      e = c[13:12];
      hit = c[15] && (c[10] ? (e[0] && k == 1 || e[1] && k == 2) :
            (k == 0 && (e == 3 || e == 1 && !cap_pin || e == 2 && cap_pin)));
      if (k == 0) cap_pin <= ~cap_pin;
      if (k == 1) cnt_in <= ~cnt_in;
      if (k == 2) dir_in <= ~dir_in;
      if (hit) capv = c[11] ? (v - 1) & 32'hffff : v;
      cap_q.push_back(capv);
      repeat (6) @(posedge pclk);
      apb(1'b0, 12'h008, 32'h0);
      check(rd, cap_q.pop_front());
      apb(1'b0, 12'h004, 32'h0);
      check(rd, (hit && c[14]) ? 0 : v);
      apb(1'b0, 12'h010, 32'h0);
      check(rd, hit ? 2 : 0);
      check(irq, hit);
    end
    // counter mode on toggle latch edges, codes 0, 1, 5, 6, 7
    for (i = 0; i < 5; i = i + 1) begin
      c = (i < 2) ? i : i + 3;
      apb(1'b1, 12'h00c, 32'h0);
      apb(1'b1, 12'h004, 32'h0);
      apb(1'b1, 12'h000, 32'h48 | c);
      lat = 0;
      exp = 0;
      // an odd pulse count leaves the latch set; the next core write clears it
      repeat (3) begin
        core_ovf <= 1'b1;
        @(posedge pclk);
        core_ovf <= 1'b0;
        repeat (3) @(posedge pclk);
        lat = 1 - lat;
        if ((c == 5 && lat == 1) || (c == 6 && lat == 0) || c == 7) exp = exp + 1;
      end
      apb(1'b0, 12'h00c, 32'h0);
      check(rd[10], lat);
      apb(1'b0, 12'h004, 32'h0);
      check(rd, exp);
    end
    // core counter mode with input code 000 stays disabled
    apb(1'b1, 12'h00c, 32'h48);
    check(core_run, 1'b0);
    apb(1'b1, 12'h00c, 32'h40);
    check(core_run, 1'b1);
    close_out;
  end
endmodule
